// >>> design/pecu_channel.sv
`timescale 1ns/1ps
// one counting channel: start/end gating and a 32-bit count
module pecu_channel #(
    parameter int W = 32
) (
    input  wire logic                   sys_clk,
    input  wire logic                   rst_n,
    input  wire pecu_pkg::pecu_cpu_ev_s ev,
    input  wire pecu_pkg::pecu_ctrl_s   ctrl,
    input  wire logic                   clear,
    input  wire logic                   carry_in,
    input  wire logic                   chain_mode,
    output logic [W-1:0]                count_q,
    output logic                        carry_out,
    output pecu_pkg::pecu_state_e       state_q
);
    logic [1:0] inc;
    pecu_event_sel u_sel (
        .ev  (ev),
        .sel (ctrl.sel),
        .inc (inc)
    );

    wire no_cond  = (ctrl.start_ch == pecu_pkg::EVCH_NONE)
                    && (ctrl.end_ch == pecu_pkg::EVCH_NONE);
    wire one_cond = !no_cond && ((ctrl.start_ch == pecu_pkg::EVCH_NONE)
                    || (ctrl.end_ch == pecu_pkg::EVCH_NONE)); // half set: never counts
    wire start_hit = no_cond ? ev.prog_start
                     : ev.break_hit[ctrl.start_ch - 4'd1];
    wire end_hit   = no_cond ? ev.halt
                     : ev.break_hit[ctrl.end_ch - 4'd1];
    wire counting  = (state_q == pecu_pkg::PECU_COUNTING);
    wire [1:0] step = chain_mode ? {1'b0, carry_in} : inc;
    wire [W:0] sum  = {1'b0, count_q} + {{(W-1){1'b0}}, step};

    assign carry_out = counting && sum[W];

    // start/end gating; a clear rearms the channel
    pecu_pkg::pecu_state_e state_d;
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            pecu_pkg::PECU_IDLE:     state_d = one_cond ? pecu_pkg::PECU_IDLE
                                                        : pecu_pkg::PECU_ARMED;
            pecu_pkg::PECU_ARMED:    if (start_hit) state_d = pecu_pkg::PECU_COUNTING;
            pecu_pkg::PECU_COUNTING: if (end_hit) state_d = pecu_pkg::PECU_DONE;
            pecu_pkg::PECU_DONE:     state_d = pecu_pkg::PECU_DONE;
        endcase
        if (clear) state_d = pecu_pkg::PECU_IDLE;
    end

    // counter runs only on sys_clk edges, so a stopped cpu clock freezes it
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            state_q <= pecu_pkg::PECU_IDLE;
            count_q <= W'(pecu_pkg::COUNT_RESET);
        end else begin
            state_q <= state_d;
            if (clear) count_q <= W'(pecu_pkg::COUNT_RESET);
            else if (counting) count_q <= sum[W-1:0];
        end
    end
endmodule

// >>> design/pecu_event_sel.sv
`timescale 1ns/1ps
// turns the core strobes into a per-selection increment (0, 1 or 2)
module pecu_event_sel (
    input  wire pecu_pkg::pecu_cpu_ev_s ev,
    input  wire pecu_pkg::pecu_sel_e    sel,
    output logic [1:0]                  inc
);
    wire run_cyc  = ~ev.power_on;
    wire br_count = (ev.uncond_branch & ~ev.exc_entry_branch)
                    | ev.return_from_exception;
    wire irq      = ev.interrupt_accepted | ev.nmi_accepted;
    // nmi is an interrupt too, so it must also show up as an exception
    wire exc      = ev.exception_accepted | irq;
    wire brk      = |ev.break_hit;

    always_comb begin
        unique case (sel)
            pecu_pkg::PECU_SEL_DISABLED:            inc = 2'd0;
            pecu_pkg::PECU_SEL_ELAPSED_CYCLES:      inc = {1'b0, run_cyc};
            pecu_pkg::PECU_SEL_PRIVILEGED_CYCLES:
                inc = {1'b0, run_cyc & ev.privileged};
            pecu_pkg::PECU_SEL_BLOCKED_CYCLES:
                inc = {1'b0, run_cyc & ev.exception_block_bit};
            pecu_pkg::PECU_SEL_INSTRUCTIONS:
                inc = {1'b0, ev.insn_done} + {1'b0, ev.insn_done & ev.dual_issue};
            pecu_pkg::PECU_SEL_DUAL_ISSUE:          inc = {1'b0, ev.dual_issue};
            pecu_pkg::PECU_SEL_UNCONDITIONAL_BRANCH: inc = {1'b0, br_count};
            pecu_pkg::PECU_SEL_EXCEPTIONS_ACCEPTED: inc = {1'b0, exc};
            pecu_pkg::PECU_SEL_INTERRUPTS:          inc = {1'b0, irq};
            pecu_pkg::PECU_SEL_BREAK_CHANNEL_HITS:  inc = {1'b0, brk};
            default:                                inc = 2'd0;
        endcase
    end
endmodule

// >>> design/pecu_pkg.sv
// Overview of operation
// - four independent channels, each with its own event selection
// - channel counts from its start condition until its end condition
// - no start/end selected: count from program run until a halting event
// - event channels 8 and 9 refused as start/end for channels 1 and 2
// - user ownership takes channels 1 and 2 away from the debugger
// - elapsed cycles: one per clock, not during power-on
// - privileged cycles: elapsed cycles spent in privileged mode
// - blocked cycles: elapsed cycles with exception block bit set
// - instructions: completed ones plus one per dual-issue cycle that completes an instruction
// - dual issue: one per cycle with two instructions executing
// - unconditional branches, not exception entry, returns counted
// - accepted exceptions, interrupts included
// - accepted interrupts, non-maskable included
// - OR of all break channel hits counted
// - disabled selection never counts
// - 32-bit result per channel, two channels chain into 64 bits
// - counters stop while the cpu clock is halted
package pecu_pkg;

    localparam int NUM_CHAN = 4;
    localparam int NUM_EVCH = 12;
    localparam int CNT_W    = 32;

    // avalon word addresses (byte address = 4 * index)
    localparam logic [5:0] ADDR_CTRL0   = 6'h00;  // ctrl, one word per channel
    localparam logic [5:0] ADDR_COUNT0  = 6'h04;  // counts, one word per channel
    localparam logic [5:0] ADDR_STATUS  = 6'h08;
    localparam logic [5:0] ADDR_OWNER   = 6'h09;

    // ctrl word field positions
    localparam int SEL_LSB   = 0;   // 4 bits event selection
    localparam int START_LSB = 4;   // 4 bits start channel, 0 = none
    localparam int END_LSB   = 8;   // 4 bits end channel, 0 = none
    localparam int CHAIN_BIT = 12;  // odd channel extends its even neighbour
    localparam int CLEAR_BIT = 31;  // bit not decoded; any accepted ctrl write whose start/end channels are not refused clears count

    localparam logic [31:0] CTRL_RESET   = 32'h0000_0000;
    localparam logic [31:0] COUNT_RESET  = 32'h0000_0000;
    localparam logic [3:0]  EVCH_NONE    = 4'h0;
    localparam logic [3:0]  EVCH_LOCK_A  = 4'h8;
    localparam logic [3:0]  EVCH_LOCK_B  = 4'h9;

    typedef enum logic [3:0] {
        PECU_SEL_DISABLED,
        PECU_SEL_ELAPSED_CYCLES,
        PECU_SEL_PRIVILEGED_CYCLES,
        PECU_SEL_BLOCKED_CYCLES,
        PECU_SEL_INSTRUCTIONS,
        PECU_SEL_DUAL_ISSUE,
        PECU_SEL_UNCONDITIONAL_BRANCH,
        PECU_SEL_EXCEPTIONS_ACCEPTED,
        PECU_SEL_INTERRUPTS,
        PECU_SEL_BREAK_CHANNEL_HITS
    } pecu_sel_e;

    typedef enum logic [1:0] {
        PECU_IDLE,
        PECU_ARMED,
        PECU_COUNTING,
        PECU_DONE
    } pecu_state_e;

    // event strobes from core and break controller
    typedef struct packed {
        logic                power_on;
        logic                privileged;
        logic                exception_block_bit;
        logic                insn_done;
        logic                dual_issue;
        logic                uncond_branch;
        logic                exc_entry_branch;
        logic                return_from_exception;
        logic                exception_accepted;
        logic                interrupt_accepted;
        logic                nmi_accepted;
        logic                prog_start;
        logic                halt;
        logic [NUM_EVCH-1:0] break_hit;
    } pecu_cpu_ev_s;

    typedef struct packed {
        logic [3:0]  end_ch;
        logic [3:0]  start_ch;
        pecu_sel_e   sel;
        logic        chain;
    } pecu_ctrl_s;

endpackage

// >>> design/pecu_top.sv
// Our own choices: the register addresses and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
// performance event counting unit with avalon-mm register access
module pecu_top #(
    parameter int NCH = pecu_pkg::NUM_CHAN
) (
    input  wire logic                   sys_clk,
    input  wire logic                   rst_n,
    input  wire pecu_pkg::pecu_cpu_ev_s cpu_ev,
    input  wire logic                   counter_ownership_setting,
    input  wire logic [5:0]             avs_address,
    input  wire logic                   avs_read,
    input  wire logic                   avs_write,
    input  wire logic [31:0]            avs_writedata,
    input  wire logic [3:0]             avs_byteenable,
    output logic [31:0]                 avs_readdata,
    output logic                        avs_waitrequest,
    output logic [1:0]                  avs_response
);
    // ownership is a pin from another domain: two flops first
    logic own_meta_q;
    logic own_sync_q;
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            own_meta_q <= 1'b0;
            own_sync_q <= 1'b0;
        end else begin
            own_meta_q <= counter_ownership_setting;
            own_sync_q <= own_meta_q;
        end
    end

    // one-cycle answer: waitrequest high on first request cycle, low next
    logic ack_q;
    wire  req      = avs_read | avs_write;
    wire  acc      = req & ack_q;
    wire  in_ctrl  = (avs_address[5:2] == pecu_pkg::ADDR_CTRL0[5:2]);
    wire  in_count = (avs_address[5:2] == pecu_pkg::ADDR_COUNT0[5:2]);
    wire  [1:0] idx = avs_address[1:0];
    wire  user_lock = own_sync_q && (idx < 2'd2);
    wire  hit_st   = (avs_address == pecu_pkg::ADDR_STATUS);
    wire  hit_own  = (avs_address == pecu_pkg::ADDR_OWNER);
    wire  mapped   = ((in_ctrl | in_count) & !user_lock) | hit_st | hit_own;

    function automatic logic [31:0] merge_be(input logic [31:0] old,
                                             input logic [31:0] nw,
                                             input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (be[b]) r[b*8 +: 8] = nw[b*8 +: 8];
        end
        return r;
    endfunction

    function automatic logic evch_ok(input logic [3:0] ch, input int chan);
        // channels 1 and 2 may not take event channels 8 and 9
        return !((chan < 2) && ((ch == pecu_pkg::EVCH_LOCK_A)
                 || (ch == pecu_pkg::EVCH_LOCK_B)));
    endfunction

    logic [31:0] ctrl_q [NCH];
    logic [31:0] count  [NCH];
    logic        carry  [NCH];
    pecu_pkg::pecu_state_e st [NCH];

    genvar g;
    generate
        for (g = 0; g < NCH; g++) begin : g_ch
            wire wr_me = acc && avs_write && in_ctrl && (idx == 2'(g)) && !user_lock;
            wire [31:0] nw = merge_be(ctrl_q[g], avs_writedata, avs_byteenable);
            wire ok = evch_ok(nw[pecu_pkg::START_LSB +: 4], g)
                      && evch_ok(nw[pecu_pkg::END_LSB +: 4], g)
                      && (nw[pecu_pkg::START_LSB +: 4] <= 4'(pecu_pkg::NUM_EVCH))
                      && (nw[pecu_pkg::END_LSB +: 4] <= 4'(pecu_pkg::NUM_EVCH));
            wire reconf = wr_me && ok;
            wire clr = reconf;

            // refused selections leave the old setting in place
            always_ff @(posedge sys_clk) begin
                if (!rst_n) ctrl_q[g] <= pecu_pkg::CTRL_RESET;
                else if (reconf) ctrl_q[g] <= {1'b0, nw[30:0]};
            end

            pecu_pkg::pecu_ctrl_s c;
            assign c.sel      = pecu_pkg::pecu_sel_e'(ctrl_q[g][pecu_pkg::SEL_LSB +: 4]);
            assign c.start_ch = ctrl_q[g][pecu_pkg::START_LSB +: 4];
            assign c.end_ch   = ctrl_q[g][pecu_pkg::END_LSB +: 4];
            assign c.chain    = ctrl_q[g][pecu_pkg::CHAIN_BIT];

            wire chain_on = (g % 2 == 1) && c.chain;
            wire cin      = (g % 2 == 1) ? carry[(g / 2) * 2] : 1'b0;

            pecu_channel #(.W(pecu_pkg::CNT_W)) u_ch (
                .sys_clk    (sys_clk),
                .rst_n      (rst_n),
                .ev         (cpu_ev),
                .ctrl       (c),
                .clear      (clr),
                .carry_in   (cin),
                .chain_mode (chain_on),
                .count_q    (count[g]),
                .carry_out  (carry[g]),
                .state_q    (st[g])
            );
        end
    endgenerate

    // status: two bits per channel (state), ownership at bit 31
    logic [31:0] status_w;
    always_comb begin
        status_w = 32'h0000_0000;
        for (int i = 0; i < NCH; i++) status_w[i*2 +: 2] = st[i];
        status_w[31] = own_sync_q;
    end

    wire [31:0] rd_mux = !mapped  ? 32'h0000_0000
                       : in_ctrl  ? ctrl_q[idx]
                       : in_count ? count[idx]
                       : hit_st   ? status_w
                       : 32'h0000_0000;

    // bus answer registers; unmapped or locked slots answer slave error
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            ack_q           <= 1'b0;
            avs_readdata    <= 32'h0000_0000;
            avs_response    <= 2'b00;
        end else begin
            ack_q        <= req & !ack_q;
            if (req && !ack_q) begin
                avs_readdata <= rd_mux;
                avs_response <= mapped ? 2'b00 : 2'b10;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) avs_waitrequest <= 1'b1;
        else avs_waitrequest <= !(req && !ack_q);
    end
endmodule

// >>> tb/pecu_core_model.sv
`timescale 1ns/1ps
// stand-in for the core and break controller strobes
module pecu_core_model (
    input  wire logic              sys_clk,
    output pecu_pkg::pecu_cpu_ev_s ev
);
    // power-on stays high until the first pattern, so nothing can count early
    initial ev = '{power_on: 1'b1, default: '0};

    // one pattern for one cycle, then one idle cycle plus gap more (slow core)
    task automatic drive(input pecu_pkg::pecu_cpu_ev_s v, input int gap);
        @(posedge sys_clk);
        ev <= v;
        @(posedge sys_clk);
        ev <= '0;
        repeat (gap) @(posedge sys_clk);
    endtask
endmodule

// >>> tb/pecu_top_checker.sv
`timescale 1ns/1ps
// register port checks; ownership is trusted only once it has settled
module pecu_checker #(
    parameter int NCH = 4
) (
    input wire logic        sys_clk,
    input wire logic        rst_n,
    input wire logic        counter_ownership_setting,
    input wire logic [5:0]  avs_address,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [31:0] avs_readdata,
    input wire logic        avs_waitrequest,
    input wire logic [1:0]  avs_response
);
    logic       own_prev_q;
    logic [1:0] own_cnt_q;
    wire        req      = avs_read || avs_write;
    wire        acc      = req && !avs_waitrequest;
    wire        settled  = own_cnt_q == 2'd3 && own_prev_q == counter_ownership_setting;
    wire        user_ch  = avs_address inside {6'h00, 6'h01, 6'h04, 6'h05};
    // stable-cycle count, covers the two-flop synchroniser in the unit
    always_ff @(posedge sys_clk) begin
        own_prev_q <= counter_ownership_setting;
        if (!rst_n || own_prev_q != counter_ownership_setting) begin
            own_cnt_q <= 2'd0;
        end else if (own_cnt_q != 2'd3) begin
            own_cnt_q <= own_cnt_q + 2'd1;
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    // handshake shape: exactly one wait cycle, high again afterwards
    a_one_wait_cycle: assert property (req && avs_waitrequest |=> !avs_waitrequest)
        else $error("request not answered after one wait cycle");
    a_wait_rises: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low for more than one cycle");
    a_idle_wait_high: assert property (!req |=> avs_waitrequest)
        else $error("waitrequest low without a request");
    a_answer_stands: assert property (
        avs_waitrequest |-> $stable(avs_readdata) && $stable(avs_response))
        else $error("read data or response changed outside an answer");
    a_unmapped_refused: assert property (acc && avs_address > 6'h09 |-> avs_response == 2'b10)
        else $error("unmapped access not refused");
    a_owned_refused: assert property (
        acc && avs_read && settled && counter_ownership_setting && user_ch
        |-> avs_response == 2'b10 && avs_readdata == 32'h0000_0000)
        else $error("user owned channel reachable from the bus");
    a_mapped_ok: assert property (
        acc && settled && !counter_ownership_setting && avs_address <= 6'h09
        |-> avs_response == 2'b00)
        else $error("mapped access refused");
    a_owner_flag: assert property (
        acc && avs_read && settled && avs_address == 6'h08
        |-> avs_readdata[31] == counter_ownership_setting)
        else $error("status ownership bit wrong");

    c_read_accept: cover property (acc && avs_read);
    c_write_accept: cover property (acc && avs_write);
    c_owned_refusal: cover property (acc && settled && counter_ownership_setting && user_ch);
endmodule

bind pecu_top pecu_checker #(.NCH(NCH)) chk_u (.sys_clk(sys_clk), .rst_n(rst_n),
    .counter_ownership_setting(counter_ownership_setting), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .avs_response(avs_response));

// >>> tb/perf_event_counter_unit_tb.sv
`timescale 1ns/1ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin error_cnt++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (e)); end end
// bench: avalon accesses against scripted core strobes
module perf_event_counter_unit_tb;
    localparam logic [1:0] OK  = 2'b00;
    localparam logic [1:0] ERR = 2'b10;
    logic                   sys_clk = 1'b0;
    logic                   rst_n = 1'b0;
    logic                   counter_ownership_setting = 1'b0;
    logic [5:0]             avs_address = 6'h00;
    logic                   avs_read = 1'b0;
    logic                   avs_write = 1'b0;
    logic [31:0]            avs_writedata = 32'h0000_0000;
    logic [31:0]            avs_readdata;
    logic                   avs_waitrequest;
    logic [1:0]             avs_response;
    pecu_pkg::pecu_cpu_ev_s cpu_ev;
    pecu_pkg::pecu_cpu_ev_s pat [11];
    logic [31:0]            exp_tab [12] = '{0, 14, 2, 1, 3, 1, 2, 3, 2, 1, 0, 0};
    int                     seq [6] = '{6, 7, 6, 6, 8, 6};
    int                     error_cnt = 0;
    int                     check_count = 0;

    always #20 sys_clk = ~sys_clk;

    // byte enables stay full: every register is accessed as a whole word
    pecu_top dut_u (.sys_clk(sys_clk), .rst_n(rst_n), .cpu_ev(cpu_ev),
        .counter_ownership_setting(counter_ownership_setting), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .avs_response(avs_response));
    pecu_core_model src_u (.sys_clk(sys_clk), .ev(cpu_ev));

    // one access, held until waitrequest is sampled low; no fixed latency assumed
    task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic [1:0] r);
        int n;
        n = 0;
        @(posedge sys_clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_read <= !w;
        avs_write <= w;
        do begin
            @(posedge sys_clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 40);
        q = avs_readdata;
        r = avs_response;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        if (n >= 40) begin
            error_cnt++;
            test_done();
        end
    endtask
    task automatic rd(input logic [5:0] a, input logic [31:0] e, input logic [1:0] er);
        logic [31:0] q;
        logic [1:0]  r;
        bus(1'b0, a, 32'h0000_0000, q, r);
        `CHK(q, e)
        `CHK(r, er)
    endtask
    task automatic wr(input logic [5:0] a, input logic [31:0] d, input logic [1:0] er);
        logic [31:0] q;
        logic [1:0]  r;
        bus(1'b1, a, d, q, r);
        `CHK(r, er)
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // watchdog: the sequence needs well under a thousand cycles
    initial begin
        #(40 * 5000);
        error_cnt++;
        test_done();
    end

    // main sequence
    initial begin
        pat[0] = '{privileged: 1'b1, insn_done: 1'b1, default: '0};
        pat[1] = '{exception_block_bit: 1'b1, insn_done: 1'b1, dual_issue: 1'b1, default: '0};
        pat[2] = '{uncond_branch: 1'b1, privileged: 1'b1, default: '0};
        pat[3] = '{uncond_branch: 1'b1, exc_entry_branch: 1'b1, exception_accepted: 1'b1,
                   default: '0};
        pat[4] = '{return_from_exception: 1'b1, interrupt_accepted: 1'b1, default: '0};
        pat[5] = '{nmi_accepted: 1'b1, break_hit: 12'h801, default: '0};
        pat[6] = '{insn_done: 1'b1, power_on: 1'b1, default: '0};
        pat[7] = '{break_hit: 12'h001, default: '0};
        pat[8] = '{insn_done: 1'b1, break_hit: 12'h002, default: '0};
        pat[9] = '{prog_start: 1'b1, default: '0};
        pat[10] = '{halt: 1'b1, default: '0};
        repeat (8) @(posedge sys_clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 8; i++) rd(6'(i), 32'h0000_0000, OK);
        // no conditions after reset, so every channel waits armed for program start
        rd(6'h08, 32'h0000_0055, OK);
        rd(6'h09, 32'h0000_0000, OK);
        $display("test reset values done");
        // every selection, four channels at once, run from program start to halt
        for (int r = 0; r < 3; r++) begin
            for (int c = 0; c < 4; c++) wr(6'(c), (4 * r + c < 10) ? 32'(4 * r + c) : 0, OK);
            src_u.drive(pat[9], 0);
            for (int i = 0; i < 6; i++) src_u.drive(pat[i], 0);
            src_u.drive(pat[10], 0);
            rd(6'h04, exp_tab[4 * r], OK);
            rd(6'h05, exp_tab[4 * r + 1], OK);
            rd(6'h06, exp_tab[4 * r + 2], OK);
            rd(6'h07, exp_tab[4 * r + 3], OK);
        end
        $display("test selections done");
        wr(6'h02, 32'h0000_0214, OK);
        wr(6'h03, 32'h0000_0014, OK);
        foreach (seq[i]) src_u.drive(pat[seq[i]], 2);
        rd(6'h06, 32'h0000_0003, OK);
        rd(6'h07, 32'h0000_0000, OK);
        rd(6'h08, 32'h0000_003F, OK);
        $display("test start end gating done");
        wr(6'h00, 32'h0000_0981, OK);
        wr(6'h01, 32'h0000_0291, OK);
        wr(6'h02, 32'h0000_0981, OK);
        rd(6'h00, 32'h0000_0008, OK);
        rd(6'h01, 32'h0000_0009, OK);
        rd(6'h02, 32'h0000_0981, OK);
        rd(6'h06, 32'h0000_0000, OK);
        $display("test event channel lock done");
        counter_ownership_setting <= 1'b1;
        repeat (4) @(posedge sys_clk);
        rd(6'h00, 32'h0000_0000, ERR);
        wr(6'h05, 32'h0000_0000, ERR);
        rd(6'h02, 32'h0000_0981, OK);
        rd(6'h08, 32'h8000_001F, OK);
        counter_ownership_setting <= 1'b0;
        repeat (4) @(posedge sys_clk);
        rd(6'h00, 32'h0000_0008, OK);
        rd(6'h0A, 32'h0000_0000, ERR);
        wr(6'h3F, 32'h0000_0001, ERR);
        $display("test ownership and map done");
        // chained odd channel only takes carries, so it stays at zero here;
        // the power-on cycle inside the run is skipped by the elapsed count
        wr(6'h02, 32'h0000_0001, OK);
        wr(6'h03, 32'h0000_1001, OK);
        src_u.drive(pat[9], 0);
        src_u.drive(pat[6], 0);
        src_u.drive(pat[10], 0);
        rd(6'h06, 32'h0000_0003, OK);
        rd(6'h07, 32'h0000_0000, OK);
        $display("test chained pair done");
        test_done();
    end
endmodule
